// [rtl/lv_gpio_pkg.sv]
package lv_gpio_pkg;

  // Register indices of the four pin control registers.
  localparam logic [5:0] LV_PIN0_CONTROL_IDX = 6'h21;
  localparam logic [5:0] LV_PIN1_CONTROL_IDX = 6'h22;
  localparam logic [5:0] LV_PIN2_CONTROL_IDX = 6'h23;
  localparam logic [5:0] LV_PIN3_CONTROL_IDX = 6'h24;

  localparam int NUM_PINS   = 4;
  localparam int REG_WIDTH  = 24;

  // Field positions.
  localparam int DIR_BIT      = 0;
  localparam int DIN_BIT      = 1;
  localparam int DOUT_BIT     = 2;
  localparam int SCHMITT_BIT  = 3;
  localparam int FILT_LSB     = 4;
  localparam int IRQ_LSB      = 6;
  localparam int KEEPER_BIT   = 8;
  localparam int DRAIN_BIT    = 9;
  localparam int DRIVE_BIT    = 10;
  localparam int RES_ON_BIT   = 11;
  localparam int RES_KIND_LSB = 12;
  localparam int EDGE_LSB     = 14;
  localparam int IMPL_BITS    = 16;

  // Reset value: schmitt, resistor on, 100 K pull-up.
  localparam logic [23:0] CONTROL_RESET = 24'h003808;
  // Bits that software may write; the input level and upper byte are excluded.
  localparam logic [23:0] WRITE_MASK    = 24'h00fffd;

  // Debounce times in milliseconds and the clock rate.
  localparam int CLK_HZ        = 100_000_000;
  localparam int FILT_MS_UNIT  = 10;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int FILT_UNIT_CYCLES = FILT_MS_UNIT * CYCLES_PER_MS;

  // Interrupt edge selection codes.
  typedef enum logic [1:0] {
    IRQ_NONE    = 2'b00,
    IRQ_FALLING = 2'b01,
    IRQ_RISING  = 2'b10,
    IRQ_BOTH    = 2'b11
  } irq_sel_t;

  // Decoded pad options of one pin, passed to the pad cell.
  typedef struct packed {
    logic       schmitt_select;
    logic       keeper_on;
    logic       drain_only_output;
    logic       drive_current_select;
    logic       resistor_on;
    logic [1:0] resistor_kind;
    logic [1:0] edge_rate;
  } pad_cfg_t;

endpackage : lv_gpio_pkg

// [rtl/lv_pin_filter.sv]
`timescale 1ns/100ps
module lv_pin_filter #(
  parameter int UNIT_CYCLES = lv_gpio_pkg::FILT_UNIT_CYCLES
) (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Synchronised pin level and debounce selection.
  input  wire logic       level_in,
  input  wire logic [1:0] filter_sel,
  // Filtered level and edge events.
  output logic            level_out,
  output logic            rise_pulse,
  output logic            fall_pulse
);
  import lv_gpio_pkg::*;

  localparam int CW = $clog2(3 * UNIT_CYCLES + 1);

  logic [CW-1:0] count_reg;
  logic          level_reg;
  logic [CW-1:0] need;
  logic          differs;

  // Required stable time is the field value times one unit.
  assign need    = CW'(filter_sel) * CW'(UNIT_CYCLES);
  assign differs = level_in != level_reg;

  // Accept a new level once it has stood for the selected time.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      level_reg <= 1'b0;
    end else if (!differs) begin
      count_reg <= '0;
    end else if (count_reg + CW'(1) >= need) begin
      level_reg <= level_in;
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + CW'(1);
    end
  end

  assign level_out  = level_reg;
  assign rise_pulse = differs && level_in && (count_reg + CW'(1) >= need);
  assign fall_pulse = differs && !level_in && (count_reg + CW'(1) >= need);

endmodule : lv_pin_filter

// [rtl/lv_gpio_ctrl.sv]
// Contract
// - Four identical per-pin control registers.
// - Bit 0 selects input or output.
// - Bit 1 reads sampled pin level.
// - Bit 2 is driven output level.
// - Bit 3 selects schmitt input, default one.
// - Bits 5:4 debounce none/10/20/30 ms.
// - Bits 7:6 pick interrupt edges.
// - Bit 8 enables pad keeper.
// - Bit 9 open drain releases high.
// - Bit 10 picks 4 or 8 mA.
// - Bit 11 resistor on, 13:12 kind.
// - Bits 15:14 set output slew rate.
// - Reset restores all field defaults.
`timescale 1ns/100ps
module lv_gpio_ctrl #(
  parameter int FILT_CYCLES = lv_gpio_pkg::FILT_UNIT_CYCLES
) (
  // Clock and main digital reset.
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  // Register access port from the serial interface.
  input  wire logic                               reg_wr,
  input  wire logic [5:0]                         reg_addr,
  input  wire logic [lv_gpio_pkg::REG_WIDTH-1:0]  reg_wdata,
  output logic      [lv_gpio_pkg::REG_WIDTH-1:0]  reg_rdata,
  output logic                                    reg_hit,
  // Low-voltage pins, output enable active low.
  input  wire logic [lv_gpio_pkg::NUM_PINS-1:0]   pin_in,
  output logic      [lv_gpio_pkg::NUM_PINS-1:0]   pin_out,
  output logic      [lv_gpio_pkg::NUM_PINS-1:0]   pin_oe_n,
  // Pad options per pin.
  output lv_gpio_pkg::pad_cfg_t [lv_gpio_pkg::NUM_PINS-1:0] pad_cfg,
  // Per-pin edge events to the interrupt logic.
  output logic      [lv_gpio_pkg::NUM_PINS-1:0]   pin_event
);
  import lv_gpio_pkg::*;

  logic [REG_WIDTH-1:0] ctrl_reg [NUM_PINS];
  logic [NUM_PINS-1:0]  sync1_reg;
  logic [NUM_PINS-1:0]  sync2_reg;
  logic [NUM_PINS-1:0]  filt_level;
  logic [NUM_PINS-1:0]  rise;
  logic [NUM_PINS-1:0]  fall;
  logic [NUM_PINS-1:0]  event_reg;
  logic [NUM_PINS-1:0]  out_reg;
  logic [NUM_PINS-1:0]  oe_n_reg;
  logic [2:0]           sel_idx;
  logic                 sel_ok;

  // Map a register index to a pin number; out-of-range gives 4.
  function automatic logic [2:0] pin_of(input logic [5:0] a);
    if (a == LV_PIN0_CONTROL_IDX) begin
      return 3'h0;
    end else if (a == LV_PIN1_CONTROL_IDX) begin
      return 3'h1;
    end else if (a == LV_PIN2_CONTROL_IDX) begin
      return 3'h2;
    end else if (a == LV_PIN3_CONTROL_IDX) begin
      return 3'h3;
    end else begin
      return 3'h4;
    end
  endfunction : pin_of

  // Address decode.
  assign sel_idx = pin_of(reg_addr);
  assign sel_ok  = sel_idx != 3'h4;
  assign reg_hit = sel_ok;

  // Read data: stored fields, live input level, zero upper byte.
  always_comb begin
    reg_rdata = '0;
    if (sel_ok) begin
      reg_rdata = ctrl_reg[sel_idx[1:0]] & WRITE_MASK;
      reg_rdata[DIN_BIT] = sync2_reg[sel_idx[1:0]];
    end
  end

  // Two-stage synchroniser on the pin inputs.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      logic [1:0] irq_sel;

      // Control register write with mask; reset restores defaults.
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          ctrl_reg[g] <= CONTROL_RESET;
        end else if (reg_wr && sel_ok && sel_idx[1:0] == 2'(g)) begin
          ctrl_reg[g] <= reg_wdata & WRITE_MASK;
        end
      end

      // Debounce filter on the synchronised level.
      lv_pin_filter #(
        .UNIT_CYCLES (FILT_CYCLES)
      ) u_filter (
        .core_clk   (core_clk),
        .rst        (rst),
        .level_in   (sync2_reg[g]),
        .filter_sel (ctrl_reg[g][FILT_LSB +: 2]),
        .level_out  (filt_level[g]),
        .rise_pulse (rise[g]),
        .fall_pulse (fall[g])
      );

      assign irq_sel = ctrl_reg[g][IRQ_LSB +: 2];

      // Edge event and pin drive, registered.
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          event_reg[g] <= 1'b0;
          out_reg[g]   <= 1'b0;
          oe_n_reg[g]  <= 1'b1;
        end else begin
          event_reg[g] <= (rise[g] && irq_sel[1]) || (fall[g] && irq_sel[0]);
          out_reg[g]   <= ctrl_reg[g][DOUT_BIT] && !ctrl_reg[g][DRAIN_BIT];
          // Drive when output; open drain drives only a low level.
          oe_n_reg[g]  <= !(ctrl_reg[g][DIR_BIT] &&
                           !(ctrl_reg[g][DRAIN_BIT] && ctrl_reg[g][DOUT_BIT]));
        end
      end

      // Pad option fields.
      assign pad_cfg[g].schmitt_select       = ctrl_reg[g][SCHMITT_BIT];
      assign pad_cfg[g].keeper_on            = ctrl_reg[g][KEEPER_BIT];
      assign pad_cfg[g].drain_only_output    = ctrl_reg[g][DRAIN_BIT];
      assign pad_cfg[g].drive_current_select = ctrl_reg[g][DRIVE_BIT];
      assign pad_cfg[g].resistor_on          = ctrl_reg[g][RES_ON_BIT];
      assign pad_cfg[g].resistor_kind        = ctrl_reg[g][RES_KIND_LSB +: 2];
      assign pad_cfg[g].edge_rate            = ctrl_reg[g][EDGE_LSB +: 2];
    end
  endgenerate

  assign pin_out   = out_reg;
  assign pin_oe_n  = oe_n_reg;
  assign pin_event = event_reg;

endmodule : lv_gpio_ctrl

// [testbench/lv_gpio_asserts.sv]
`timescale 1ns/100ps
module lv_gpio_asserts (
  // Clock and reset.
  input wire logic                                    core_clk,
  input wire logic                                    rst,
  // Register port.
  input wire logic                                    reg_wr,
  input wire logic [5:0]                              reg_addr,
  input wire logic [lv_gpio_pkg::REG_WIDTH-1:0]       reg_wdata,
  input wire logic [lv_gpio_pkg::REG_WIDTH-1:0]       reg_rdata,
  input wire logic                                    reg_hit,
  // Pins, pad options and events.
  input wire logic [lv_gpio_pkg::NUM_PINS-1:0]        pin_in,
  input wire logic [lv_gpio_pkg::NUM_PINS-1:0]        pin_out,
  input wire logic [lv_gpio_pkg::NUM_PINS-1:0]        pin_oe_n,
  input wire lv_gpio_pkg::pad_cfg_t [lv_gpio_pkg::NUM_PINS-1:0] pad_cfg,
  input wire logic [lv_gpio_pkg::NUM_PINS-1:0]        pin_event
);
  import lv_gpio_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // A write to the pin 0 register.
  sequence s_wr0;
    reg_wr && reg_addr == LV_PIN0_CONTROL_IDX;
  endsequence
  a_hit_decode: assert property (reg_hit == (reg_addr >= 6'h21 && reg_addr <= 6'h24))
    else $error("register decode wrong");
  a_write_back: assert property (s_wr0 |=> reg_addr != LV_PIN0_CONTROL_IDX ||
    (reg_rdata & WRITE_MASK) == ($past(reg_wdata) & WRITE_MASK)) else $error("written value not read back");
  a_oe_follow: assert property (s_wr0 |=> ##1 pin_oe_n[0] ==
    !($past(reg_wdata[0], 2) && !($past(reg_wdata[9], 2) && $past(reg_wdata[2], 2)))) else $error("enable wrong");
  a_level_follow: assert property (s_wr0 ##2 $past(reg_wdata[0], 2) |->
    pin_out[0] == ($past(reg_wdata[2], 2) && !$past(reg_wdata[9], 2))) else $error("driven level wrong");
  a_pad_map: assert property (reg_addr == LV_PIN0_CONTROL_IDX |-> pad_cfg[0] == {reg_rdata[3],
    reg_rdata[8], reg_rdata[9], reg_rdata[10], reg_rdata[11], reg_rdata[13:12], reg_rdata[15:14]})
    else $error("pad options wrong");
  a_upper_zero: assert property (reg_rdata[23:16] == 8'h00)
    else $error("upper byte not zero");
  a_unmapped_zero: assert property (!reg_hit |-> reg_rdata == 24'h000000)
    else $error("unmapped read not zero");
  a_din_sync: assert property (reg_addr == LV_PIN0_CONTROL_IDX && !$past(rst) && !$past(rst, 2) |->
    reg_rdata[1] == $past(pin_in[0], 2)) else $error("input level wrong");
  a_reset_idle: assert property (disable iff (1'b0) rst |-> pin_oe_n == 4'hf && pin_out == 4'h0 &&
    pin_event == 4'h0) else $error("outputs active in reset");
endmodule : lv_gpio_asserts

bind lv_gpio_ctrl lv_gpio_asserts checker_i (.core_clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
  .reg_hit, .pin_in, .pin_out, .pin_oe_n, .pad_cfg, .pin_event);

// [testbench/lv_board.sv]
`timescale 1ns/100ps
module lv_board (
  // Pad drive from the device.
  input  wire logic [lv_gpio_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [lv_gpio_pkg::NUM_PINS-1:0] pin_oe_n,
  // Board drivers set by the bench.
  input  wire logic [lv_gpio_pkg::NUM_PINS-1:0] ext_drv,
  input  wire logic [lv_gpio_pkg::NUM_PINS-1:0] ext_en,
  // Resolved pad level.
  output logic      [lv_gpio_pkg::NUM_PINS-1:0] pin_in
);
  import lv_gpio_pkg::*;
  // A released pad with no board driver is held high by the board resistor.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_drv[i] : 1'b1);
    end
  end
endmodule : lv_board

// [testbench/lv_gpio_ctrl_test.sv]
`timescale 1ns/100ps
module lv_gpio_ctrl_test;
  import lv_gpio_pkg::*;
  localparam int FC = 10;
  logic           core_clk, rst, reg_wr, reg_hit;
  logic [5:0]     reg_addr;
  logic [23:0]    reg_wdata, reg_rdata;
  logic [3:0]     pin_in, pin_out, pin_oe_n, pin_event, ext_drv, ext_en;
  pad_cfg_t [3:0] pad_cfg;
  int             n_mismatch, num_checks, ev[4];
  lv_gpio_ctrl #(.FILT_CYCLES(FC)) dut (.core_clk, .rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .pin_in, .pin_out, .pin_oe_n, .pad_cfg, .pin_event);
  lv_board board (.pin_out, .pin_oe_n, .ext_drv, .ext_en, .pin_in);
  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Counts event pulses per pin.
  always @(posedge core_clk) for (int i = 0; i < 4; i++) if (pin_event[i] === 1'b1) ev[i]++;
  task automatic chk(input logic [23:0] seen, exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    @(negedge core_clk);
  endtask : wr
  // Holds the index for one full cycle and compares the read word at the next falling edge.
  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    reg_addr = a;
    @(negedge core_clk);
    chk(reg_rdata, exp, "reg_rdata");
  endtask : rd
  // Raises a board pin for hi cycles, then holds it low long enough to settle.
  task automatic pulse(input int p, hi);
    ev = '{default: 0};
    ext_drv[p] = 1'b1;
    repeat (hi) @(negedge core_clk);
    ext_drv[p] = 1'b0;
    repeat (hi + 8) @(negedge core_clk);
  endtask : pulse
  task automatic close_out;
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // Main sequence.
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 24'h000000;
    ext_drv = 4'h0;
    ext_en = 4'hf;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    for (int a = 'h21; a <= 'h24; a++) begin
      rd(6'(a), CONTROL_RESET);
      chk(24'(pad_cfg[a - 'h21]), 24'h00011c, "pad_cfg reset");
    end
    for (int a = 'h20; a <= 'h25; a++) begin
      wr(6'(a), 24'hffffff);
      rd(6'(a), (a > 'h20 && a < 'h25) ? 24'h00fffd : 24'h000000);
      chk(24'(reg_hit), 24'(a > 'h20 && a < 'h25), "reg_hit");
      if (a > 'h20 && a < 'h25) chk(24'(pad_cfg[a - 'h21]), 24'h0001ff, "pad_cfg");
      wr(6'(a), 24'h000000);
      rd(6'(a), 24'h000000);
    end
    ext_en = 4'he;
    wr(LV_PIN0_CONTROL_IDX, 24'h000005);
    chk(24'({pin_oe_n[0], pin_out[0]}), 24'h1, "pin0 drive");
    repeat (2) @(negedge core_clk);
    rd(LV_PIN0_CONTROL_IDX, 24'h000007);
    wr(LV_PIN0_CONTROL_IDX, 24'h000205);
    chk(24'({pin_oe_n[0], pin_out[0]}), 24'h2, "pin0 release");
    wr(LV_PIN0_CONTROL_IDX, 24'h000201);
    repeat (2) @(negedge core_clk);
    chk(24'({pin_oe_n[0], pin_out[0]}), 24'h0, "pin0 sink");
    rd(LV_PIN0_CONTROL_IDX, 24'h000201);
    for (int c = 0; c < 4; c++) begin
      wr(LV_PIN1_CONTROL_IDX, 24'(c << 6));
      pulse(1, 5);
      chk(24'(ev[1]), 24'(c == 3 ? 2 : c != 0), "edge events");
    end
    for (int f = 1; f < 4; f++) begin
      wr(LV_PIN2_CONTROL_IDX, 24'h000080 | 24'(f << 4));
      pulse(2, f * FC - 3);
      chk(24'(ev[2]), 24'h0, "glitch events");
      pulse(2, f * FC + 6);
      chk(24'(ev[2]), 24'h1, "debounced events");
    end
    wr(LV_PIN3_CONTROL_IDX, 24'h00c7c0);
    chk(24'(pad_cfg[3]), 24'h0000e3, "pad_cfg pattern");
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk(24'({pin_oe_n[0], pin_out[0]}), 24'h2, "pin0 after reset");
    rd(LV_PIN3_CONTROL_IDX, CONTROL_RESET);
    close_out();
  end
endmodule : lv_gpio_ctrl_test
